// file: pic_pkg.sv
// package: command encodings, register layout and reset values for the priority controller
package pic_pkg;

    // register bus offsets (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_CMD_LOW   = 8'h00;
    localparam logic [7:0] ADDR_CMD_HIGH  = 8'h04;
    localparam logic [7:0] ADDR_REQUEST   = 8'h08;
    localparam logic [7:0] ADDR_SERVICE   = 8'h0c;
    localparam logic [7:0] ADDR_MASK      = 8'h10;
    localparam logic [7:0] ADDR_STATUS    = 8'h14;
    localparam logic [7:0] ADDR_ACK       = 8'h18;

    // command word field positions
    localparam int BIT_ROTATE  = 7;
    localparam int BIT_SPEC    = 6;
    localparam int BIT_EOI     = 5;
    localparam int BIT_INIT    = 4;
    localparam int BIT_MODE    = 3;
    localparam int BIT_SMM_SET = 5;
    localparam int BIT_SMM_EN  = 6;

    // reset values
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [2:0] LOWEST_RESET = 3'h7;
    localparam logic [7:0] BITS_RESET   = 8'h00;

    // status word layout
    localparam int STAT_SMM   = 0;
    localparam int STAT_IRQ   = 1;
    localparam int STAT_INIT  = 2;
    localparam int STAT_LOW_L = 4;

    typedef enum logic [2:0] {
        PIC_CMD_NONE,
        PIC_CMD_NS_EOI,
        PIC_CMD_SP_EOI,
        PIC_CMD_ROT_AUTO,
        PIC_CMD_ROT_SPEC,
        PIC_CMD_SET_PRIO
    } pic_cmd_t;

    typedef struct packed {
        pic_cmd_t   cmd;
        logic [2:0] level;
    } pic_prio_cmd_t;

    typedef struct packed {
        logic [7:0] best_onehot;
        logic [2:0] best_level;
        logic       valid;
    } pic_pick_t;

endpackage : pic_pkg

// file: pic_sync3.sv
// three-stage synchroniser for the request pins
`timescale 1ns/1ps
module pic_sync3 (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    // pins
    input  wire logic [7:0] pin_in,
    // synchronised level
    output logic      [7:0] level_out
);
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] lvl_q;
    logic [7:0] agree;

    assign agree     = ~(s2_q ^ s3_q);
    assign level_out = lvl_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q  <= 8'h00;
            s2_q  <= 8'h00;
            s3_q  <= 8'h00;
            lvl_q <= 8'h00;
        end
        else if (clk_en)
        begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= (agree & s2_q) | (~agree & lvl_q);
        end
    end
endmodule : pic_sync3

// file: pic_resolver.sv
// rotating priority resolver: finds the best candidate from a lowest-priority pointer
`timescale 1ns/1ps
module pic_resolver (
    // candidates and priority order
    input  wire logic [7:0]       cand,
    input  wire logic [2:0]       lowest,
    // result
    output pic_pkg::pic_pick_t    pick
);
    function automatic pic_pkg::pic_pick_t find_best(input logic [7:0] c, input logic [2:0] low);
        pic_pkg::pic_pick_t r;
        logic [2:0]         idx;
        r = '{best_onehot: 8'h00, best_level: 3'h0, valid: 1'b0};
        for (int k = 7; k >= 0; k--)
        begin
            idx = 3'(low + 3'(k) + 3'h1);
            if (c[idx])
            begin
                r.best_onehot = 8'h01 << idx;
                r.best_level  = idx;
                r.valid       = 1'b1;
            end
        end
        return r;
    endfunction : find_best

    assign pick = find_best(cand, lowest);
endmodule : pic_resolver

// file: pic_core.sv
// priority, end-of-service, rotation and mask logic of the eight-input controller with apb access
`timescale 1ns/1ps
module pic_core (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // request pins
    input  wire logic [7:0]  request_input,
    // interrupt request to processor
    output logic             irq
);
    logic [7:0]  request_latch_bits_q;
    logic [7:0]  request_latch_bits_d;
    logic [7:0]  in_service_bits_q;
    logic [7:0]  in_service_bits_d;
    logic [7:0]  interrupt_mask_bits_q;
    logic [7:0]  interrupt_mask_bits_d;
    logic        special_mask_flag_q;
    logic        special_mask_flag_d;
    logic [2:0]  lowest_q;
    logic [2:0]  lowest_d;
    logic        init_done_q;
    logic        init_done_d;
    logic        await_second_q;
    logic        await_second_d;
    logic [7:0]  req_prev_q;
    logic        irq_q;
    logic [31:0] prdata_q;

    logic [7:0]  req_level;
    logic [7:0]  req_rise;
    logic        wr_access;
    logic        rd_access;
    logic        wr_low;
    logic        wr_high;
    logic        wr_ack;
    logic [7:0]  wdata;
    logic        is_init_word;
    logic        is_prio_word;
    logic        is_mode_word;
    logic        addr_ok;
    pic_pkg::pic_prio_cmd_t prio_cmd;
    logic [7:0]  blocking_service;
    logic [7:0]  candidates;
    logic [7:0]  service_view;
    pic_pkg::pic_pick_t req_pick;
    pic_pkg::pic_pick_t svc_pick;
    logic        raise_irq;
    logic [7:0]  level_onehot;
    logic [7:0]  clear_service;
    logic [7:0]  set_service;
    logic [31:0] status_word;
    logic [31:0] read_mux;

    function automatic pic_pkg::pic_cmd_t decode_prio(input logic [7:0] w);
        logic [2:0] top;
        top = w[7:5];
        case (top)
            3'h1:    return pic_pkg::PIC_CMD_NS_EOI;
            3'h3:    return pic_pkg::PIC_CMD_SP_EOI;
            3'h5:    return pic_pkg::PIC_CMD_ROT_AUTO;
            3'h7:    return pic_pkg::PIC_CMD_ROT_SPEC;
            3'h6:    return pic_pkg::PIC_CMD_SET_PRIO;
            default: return pic_pkg::PIC_CMD_NONE;
        endcase
    endfunction : decode_prio

    // a pin edge reaches the request latch five edges after the pin rises
    pic_sync3 u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .pin_in    (request_input),
        .level_out (req_level)
    );

    // apb decode; zero wait states
    assign wr_access = psel & penable & pwrite & clk_en;
    assign rd_access = psel & penable & ~pwrite & clk_en;
    assign wdata     = pwdata[7:0];
    assign addr_ok   = (paddr == pic_pkg::ADDR_CMD_LOW) | (paddr == pic_pkg::ADDR_CMD_HIGH)
                     | (paddr == pic_pkg::ADDR_REQUEST) | (paddr == pic_pkg::ADDR_SERVICE)
                     | (paddr == pic_pkg::ADDR_MASK) | (paddr == pic_pkg::ADDR_STATUS)
                     | (paddr == pic_pkg::ADDR_ACK);
    assign wr_low    = wr_access & (paddr == pic_pkg::ADDR_CMD_LOW);
    assign wr_high   = wr_access & (paddr == pic_pkg::ADDR_CMD_HIGH);
    assign wr_ack    = wr_access & (paddr == pic_pkg::ADDR_ACK);
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~addr_ok;

    // command word classification
    assign is_init_word = wr_low & wdata[pic_pkg::BIT_INIT];
    assign is_prio_word = wr_low & ~wdata[pic_pkg::BIT_INIT] & ~wdata[pic_pkg::BIT_MODE];
    assign is_mode_word = wr_low & ~wdata[pic_pkg::BIT_INIT] & wdata[pic_pkg::BIT_MODE];
    assign prio_cmd.cmd   = is_prio_word ? decode_prio(wdata) : pic_pkg::PIC_CMD_NONE;
    assign prio_cmd.level = wdata[2:0];
    assign level_onehot   = 8'h01 << prio_cmd.level;

    // request latching ignores the mask
    assign req_rise = req_level & ~req_prev_q;

    // masked levels stop blocking in special mask mode
    assign blocking_service = special_mask_flag_q ? (in_service_bits_q & ~interrupt_mask_bits_q)
                                                  : in_service_bits_q;
    assign candidates   = request_latch_bits_q & ~interrupt_mask_bits_q;
    assign service_view = in_service_bits_q;

    pic_resolver u_req_pick (
        .cand   (candidates),
        .lowest (lowest_q),
        .pick   (req_pick)
    );

    pic_resolver u_svc_pick (
        .cand   (service_view),
        .lowest (lowest_q),
        .pick   (svc_pick)
    );

    // rank compare: every blocking level above the request in rotation order outranks it
    logic [7:0] outrank_mask;
    always_comb
    begin
        logic [2:0] idx;
        idx          = 3'h0;
        outrank_mask = 8'h00;
        for (int k = 0; k < 8; k++)
        begin
            idx = 3'(lowest_q + 3'(k) + 3'h1);
            if (3'(idx) == req_pick.best_level)
            begin
                break;
            end
            outrank_mask[idx] = 1'b1;
        end
    end

    // equal or higher blocking levels suppress the interrupt
    assign raise_irq = init_done_q & req_pick.valid
                     & ((blocking_service & (outrank_mask | req_pick.best_onehot)) == 8'h00);

    // end-of-service clearing and priority pointer update
    always_comb
    begin
        clear_service = 8'h00;
        lowest_d      = lowest_q;
        // commands that name a level take it from the three low data bits
        case (prio_cmd.cmd)
            pic_pkg::PIC_CMD_NS_EOI:
            begin
                clear_service = svc_pick.best_onehot;
            end
            pic_pkg::PIC_CMD_SP_EOI:
            begin
                clear_service = level_onehot;
            end
            pic_pkg::PIC_CMD_ROT_AUTO:
            begin
                clear_service = svc_pick.best_onehot;
                if (svc_pick.valid)
                begin
                    lowest_d = svc_pick.best_level;
                end
            end
            pic_pkg::PIC_CMD_ROT_SPEC:
            begin
                clear_service = level_onehot;
                lowest_d      = prio_cmd.level;
            end
            pic_pkg::PIC_CMD_SET_PRIO:
            begin
                lowest_d = prio_cmd.level;
            end
            default:
            begin
                clear_service = 8'h00;
            end
        endcase
        if (is_init_word)
        begin
            lowest_d = pic_pkg::LOWEST_RESET;
        end
    end

    // software acknowledge takes the current winner
    // and clears its request in the same cycle
    assign set_service = (wr_ack & raise_irq) ? req_pick.best_onehot : 8'h00;

    // next register values; an initialization word overrides every other update
    always_comb
    begin
        in_service_bits_d    = (in_service_bits_q & ~clear_service) | set_service;
        request_latch_bits_d = (request_latch_bits_q & ~set_service) | req_rise;
        interrupt_mask_bits_d = interrupt_mask_bits_q;
        special_mask_flag_d   = special_mask_flag_q;
        init_done_d           = init_done_q;
        await_second_d        = await_second_q;
        if (is_init_word)
        begin
            in_service_bits_d     = pic_pkg::BITS_RESET;
            request_latch_bits_d  = pic_pkg::BITS_RESET;
            interrupt_mask_bits_d = pic_pkg::MASK_RESET;
            special_mask_flag_d   = 1'b0;
            init_done_d           = 1'b0;
            await_second_d        = 1'b1;
        end
        else if (wr_high & await_second_q)
        begin
            init_done_d    = 1'b1;
            await_second_d = 1'b0;
        end
        else if (wr_high & init_done_q)
        begin
            interrupt_mask_bits_d = wdata;
        end
        if (is_mode_word & wdata[pic_pkg::BIT_SMM_EN])
        begin
            special_mask_flag_d = wdata[pic_pkg::BIT_SMM_SET];
        end
    end

    // status and readback
    // status holds the special mask flag, irq, init done and the lowest-priority pointer
    assign status_word = {24'h000000, 1'b0, lowest_q, 1'b0, init_done_q, irq_q, special_mask_flag_q};
    assign read_mux = (paddr == pic_pkg::ADDR_REQUEST) ? {24'h000000, request_latch_bits_q}
                    : (paddr == pic_pkg::ADDR_SERVICE) ? {24'h000000, in_service_bits_q}
                    : (paddr == pic_pkg::ADDR_MASK)    ? {24'h000000, interrupt_mask_bits_q}
                    : (paddr == pic_pkg::ADDR_STATUS)  ? status_word
                    : 32'h00000000;
    assign prdata = prdata_q;
    assign irq    = irq_q;

    // request and in-service registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            request_latch_bits_q <= pic_pkg::BITS_RESET;
            in_service_bits_q    <= pic_pkg::BITS_RESET;
        end
        else if (clk_en)
        begin
            request_latch_bits_q <= request_latch_bits_d;
            in_service_bits_q    <= in_service_bits_d;
        end
    end

    // mask and special mask flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_mask_bits_q <= pic_pkg::MASK_RESET;
            special_mask_flag_q   <= 1'b0;
        end
        else if (clk_en)
        begin
            interrupt_mask_bits_q <= interrupt_mask_bits_d;
            special_mask_flag_q   <= special_mask_flag_d;
        end
    end

    // priority pointer and initialization progress
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lowest_q       <= pic_pkg::LOWEST_RESET;
            init_done_q    <= 1'b0;
            await_second_q <= 1'b0;
        end
        else if (clk_en)
        begin
            lowest_q       <= lowest_d;
            init_done_q    <= init_done_d;
            await_second_q <= await_second_d;
        end
    end

    // request edge history and interrupt pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_prev_q <= 8'h00;
            irq_q      <= 1'b0;
        end
        else if (clk_en)
        begin
            req_prev_q <= req_level;
            irq_q      <= raise_irq;
        end
    end

    // read data registered on the setup cycle so it is valid in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
        end
        else if (clk_en & psel & ~penable & ~pwrite)
        begin
            prdata_q <= read_mux;
        end
    end

    // upper write data and the read strobe are not needed by any register
    logic unused_bits;
    assign unused_bits = ^{pwdata[31:8], rd_access};
endmodule : pic_core

// file: pic_core_asserts.sv
// checker for the controller's bus answers and interrupt pin
`timescale 1ns/1ps
module pic_core_asserts (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins
    input wire logic [7:0]  request_input,
    input wire logic        irq
);
    logic pend_q;
    logic done_q;
    wire  acc_w   = psel && penable && clk_en;
    wire  rdset_w = psel && !penable && !pwrite && clk_en;
    wire  bad_w   = (paddr[1:0] != 2'h0) || (paddr > pic_pkg::ADDR_ACK);
    wire  init_w  = acc_w && pwrite && paddr == pic_pkg::ADDR_CMD_LOW && pwdata[pic_pkg::BIT_INIT];
    wire  high_w  = acc_w && pwrite && paddr == pic_pkg::ADDR_CMD_HIGH;

    // tracks the first completed initialization
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            pend_q <= init_w | (pend_q & ~high_w);
            done_q <= done_q | (pend_q & high_w);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_always: assert property (pready)
        else $error("pready low");
    a_slverr_map: assert property (pslverr == (psel && penable && bad_w))
        else $error("pslverr wrong for address");
    a_rdata_hold: assert property (!rdset_w |=> $stable(prdata))
        else $error("prdata changed without read setup");
    a_rdata_upper: assert property (rdset_w |=> prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    a_unmapped_zero: assert property (rdset_w && bad_w |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_status_irq: assert property (rdset_w && paddr == pic_pkg::ADDR_STATUS |=> prdata[pic_pkg::STAT_IRQ] == $past(irq))
        else $error("status irq bit differs from pin");
    a_no_irq_early: assert property (!done_q |-> !irq)
        else $error("irq before initialization");
    a_mask_all_quiet: assert property (done_q && high_w && pwdata[7:0] == 8'hff |-> ##2 !irq [*3])
        else $error("irq with all inputs masked");
endmodule : pic_core_asserts

bind pic_core pic_core_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .request_input(request_input), .irq(irq)
);

// file: pic_host.sv
// host model: apb master issuing command words
`timescale 1ns/1ps
module pic_host (
    // clock
    input  wire logic        pclk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // one transfer; released address and data show the inverse
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer
endmodule : pic_host

// file: tb_top.sv
// self-checking bench: random command traffic against a behavioural model
`timescale 1ns/1ps
module tb_top;
    logic        pclk;
    logic        presetn;
    logic        clk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        e;
    logic [7:0]  paddr;
    logic [7:0]  req;
    logic [7:0]  op;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] d;
    logic [31:0] r;
    logic [7:0]  ops [8] = '{8'h20, 8'h60, 8'ha0, 8'he0, 8'hc0, 8'h68, 8'h48, 8'h28};
    int          failures;
    int          checks;
    int          cycles;
    int          seed;
    int          in_service_bits;
    int          request_latch_bits;
    int          interrupt_mask_bits;
    int          low;
    int          special_mask_flag;
    int          b;

    pic_core uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .request_input(req), .irq(irq));
    pic_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #4 pclk = ~pclk;

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            end_of_test();
        end
    end

    function automatic int best(input int bits);
        for (int k = 1; k <= 8; k++)
            if (bits[(low + k) % 8])
                return (low + k) % 8;
        return -1;
    endfunction : best

    function automatic int fire();
        int c;
        int s;
        c = best(request_latch_bits & ~interrupt_mask_bits);
        s = best(special_mask_flag ? in_service_bits & ~interrupt_mask_bits : in_service_bits);
        return c >= 0 && (s < 0 || (c - low + 7) % 8 < (s - low + 7) % 8);
    endfunction : fire

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.xfer(1'b1, a, {24'h0, v}, d, e);
    endtask : wr

    task automatic pulse(input logic [7:0] v);
        req <= v;
        repeat (6) @(posedge pclk);
        req <= 8'h00;
        repeat (6) @(posedge pclk);
        request_latch_bits |= v;
    endtask : pulse

    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, d, e);
    endtask : rd

    task automatic verify();
        repeat (2) @(posedge pclk);
        #1;
        check("irq", irq, fire());
        rd(pic_pkg::ADDR_SERVICE);
        check("in_service", d, in_service_bits);
        rd(pic_pkg::ADDR_MASK);
        check("mask", d, interrupt_mask_bits);
        rd(pic_pkg::ADDR_REQUEST);
        check("requests", d, request_latch_bits);
        rd(pic_pkg::ADDR_STATUS);
        check("status", d & 32'h77, low << 4 | 4 | fire() << 1 | special_mask_flag);
    endtask : verify

    task automatic end_of_test();
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        seed = 32'h2b88a5d5;
        pclk = 1'b0;
        presetn = 1'b0;
        clk_en = 1'b1;
        req = 8'h00;
        low = 7;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wr(pic_pkg::ADDR_CMD_HIGH, 8'hff);
        wr(pic_pkg::ADDR_CMD_LOW, 8'h13);
        wr(pic_pkg::ADDR_CMD_HIGH, 8'h00);
        verify();
        host.xfer(1'b0, 8'h1c, 32'h0, d, e);
        check("slverr", e, 1);
        check("unmapped", d, 0);
        wr(pic_pkg::ADDR_CMD_HIGH, 8'hff);
        interrupt_mask_bits = 8'hff;
        pulse(8'h81);
        verify();
        wr(pic_pkg::ADDR_CMD_HIGH, 8'h00);
        interrupt_mask_bits = 0;
        verify();
        wr(pic_pkg::ADDR_CMD_LOW, 8'h68);
        special_mask_flag = 1;
        wr(pic_pkg::ADDR_CMD_LOW, 8'hc3);
        low = 3;
        verify();
        wr(pic_pkg::ADDR_CMD_LOW, 8'h13);
        wr(pic_pkg::ADDR_CMD_HIGH, 8'h00);
        request_latch_bits = 0;
        in_service_bits = 0;
        interrupt_mask_bits = 0;
        special_mask_flag = 0;
        low = 7;
        verify();
        repeat (300)
        begin
            r = $random(seed);
            b = best(in_service_bits);
            op = ops[r[10:8]] | (ops[r[10:8]][6] && !ops[r[10:8]][3] ? r[14:12] : 8'h0);
            if (r[2:0] < 2)
            begin
                pulse(r[23:16]);
            end
            else if (r[2:0] == 2)
            begin
                wr(pic_pkg::ADDR_CMD_HIGH, r[23:16]);
                interrupt_mask_bits = r[23:16];
            end
            else if (r[2:0] < 5)
            begin
                if (fire())
                begin
                    b = best(request_latch_bits & ~interrupt_mask_bits);
                    in_service_bits[b] = 1;
                    request_latch_bits[b] = 0;
                end
                wr(pic_pkg::ADDR_ACK, 8'h00);
            end
            else if (r[2:0] == 5)
            begin
                clk_en <= 1'b0;
                wr(pic_pkg::ADDR_CMD_HIGH, r[23:16]);
                clk_en <= 1'b1;
            end
            else
            begin
                if (op == 8'h20 && low != 7)
                    op = 8'h60 | r[14:12];
                if (op == 8'h68)
                begin
                    interrupt_mask_bits |= in_service_bits;
                    wr(pic_pkg::ADDR_CMD_HIGH, interrupt_mask_bits[7:0]);
                end
                wr(pic_pkg::ADDR_CMD_LOW, op);
                if (op[3] && op[6])
                    special_mask_flag = op[5];
                else if (op == 8'h20 && b >= 0)
                    in_service_bits[b] = 0;
                else if (op == 8'ha0 && b >= 0)
                begin
                    in_service_bits[b] = 0;
                    low = b;
                end
                else if (op[7:3] == 5'b01100)
                    in_service_bits[op[2:0]] = 0;
                else if (op[7:3] == 5'b11100)
                begin
                    in_service_bits[op[2:0]] = 0;
                    low = op[2:0];
                end
                else if (op[7:3] == 5'b11000)
                    low = op[2:0];
            end
            verify();
        end
        end_of_test();
    end
endmodule : tb_top
